// ==== sim/sqg_global_ctrl_tb.sv ====
/*
  Self-checking bench for the QoS, snooping and mirror global control group.
  Assumes sqg_params.svh on the include path and the design compiled before.
*/
`timescale 1ns/100ps
`include "sqg_params.svh"
module sqg_global_ctrl_tb;
  import sqg_pkg::*;
  logic        sys_clk, reset, clkEn, regWr, regRd;
  logic [15:0] regAddr;
  sqg_byte_t   regWdata, regRdata, nextHdr, hopNextHdr;
  logic        dscpValid, dscpHit, pktIsIgmp, igmpToHost, ipv6Valid, mldToHost;
  sqg_dscp_t   dscpIn;
  sqg_prio3_t  dscpPrio;
  logic        mirValid, portMirrorEn, srcMatch, dstMatch, mirrorFrame;
  sqg_color_t  redDscp, yellowDscp, greenDscp;
  logic        ptpValid, ptpIsEvent, ptpEvValid, ptpNeValid;
  sqg_prio4_t  qosPrio, ptpEvPrio, ptpNePrio;
  int          fail_count, checked, cycles;
  sqg_byte_t   hdrs[8] = '{8'h01, 8'h3A, 8'h2B, 8'h2C, 8'h32, 8'h33, 8'h3C, 8'h11};
  sqg_byte_t   ctrls[3] = '{8'h04, 8'h0C, 8'h08};
  logic        hit;

  sqg_global_ctrl #(.ADDR_W(16)) uut (
    .sys_clk(sys_clk), .reset(reset), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .dscpValid(dscpValid), .dscpIn(dscpIn),
    .dscpHit(dscpHit), .dscpPrio(dscpPrio), .pktIsIgmp(pktIsIgmp), .igmpToHost(igmpToHost),
    .ipv6Valid(ipv6Valid), .nextHdr(nextHdr), .hopNextHdr(hopNextHdr), .mldToHost(mldToHost),
    .mirValid(mirValid), .portMirrorEn(portMirrorEn), .srcMatch(srcMatch), .dstMatch(dstMatch),
    .mirrorFrame(mirrorFrame), .redDscp(redDscp), .yellowDscp(yellowDscp), .greenDscp(greenDscp),
    .ptpValid(ptpValid), .ptpIsEvent(ptpIsEvent), .qosPrio(qosPrio), .ptpEvValid(ptpEvValid),
    .ptpEvPrio(ptpEvPrio), .ptpNeValid(ptpNeValid), .ptpNePrio(ptpNePrio)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // Hang guard: whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr    <= 1'b0;
  endtask : wr

  // Read data only stands in the cycle after the strobe edge
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    #1;
    chk(regRdata, exp);
  endtask : rd

  // Valids are set by the caller; result is looked at one cycle on
  task automatic pulse;
    @(posedge sys_clk);
    dscpValid <= 1'b0;
    pktIsIgmp <= 1'b0;
    ipv6Valid <= 1'b0;
    mirValid  <= 1'b0;
    ptpValid  <= 1'b0;
    #1;
  endtask : pulse

  task automatic dscp(input logic [5:0] c, input logic h, input logic [2:0] p);
    @(posedge sys_clk);
    dscpValid <= 1'b1;
    dscpIn    <= c;
    pulse();
    chk(dscpHit, h);
    chk(dscpPrio, p);
  endtask : dscp

  task automatic ptp(input logic ev, input logic [3:0] q, input logic [3:0] exp);
    @(posedge sys_clk);
    ptpValid   <= 1'b1;
    ptpIsEvent <= ev;
    qosPrio    <= q;
    pulse();
    chk(ptpEvValid, ev);
    chk(ptpNeValid, !ev);
    chk(ev ? ptpEvPrio : ptpNePrio, exp);
  endtask : ptp

  initial begin
    {regWr, regRd, dscpValid, pktIsIgmp, ipv6Valid, mirValid, ptpValid} = '0;
    {portMirrorEn, srcMatch, dstMatch, ptpIsEvent} = '0;
    regAddr = 16'h0000;
    regWdata = 8'h00;
    dscpIn = 6'h00;
    nextHdr = 8'h00;
    hopNextHdr = 8'h00;
    qosPrio = 4'h0;
    clkEn = 1'b1;
    reset = 1'b1;
    fail_count = 0;
    checked = 0;
    cycles = 0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;

    rd(`SQG_OFS_DSCP_LAST, 8'h00);
    rd(`SQG_OFS_SNOOP_CTRL, 8'h00);
    rd(`SQG_OFS_COLOR_MAP, 8'h39);
    rd(`SQG_OFS_PTP_EVENT, 8'h0F);
    rd(`SQG_OFS_PTP_NONEVT, 8'h0F);
    rd(16'h0371, 8'h00);
    @(posedge sys_clk);
    #1;
    chk(regRdata, 8'h00);
    chk({redDscp, yellowDscp, greenDscp}, 8'h39);
    $display("reset values done");

    // All-ones writes, one idle cycle apart, keep only the defined fields
    wr(`SQG_OFS_DSCP_LAST, 8'hFF);
    wr(`SQG_OFS_SNOOP_CTRL, 8'hFF);
    wr(`SQG_OFS_COLOR_MAP, 8'hFF);
    wr(`SQG_OFS_PTP_EVENT, 8'hFF);
    wr(`SQG_OFS_PTP_NONEVT, 8'hFF);
    wr(16'h0371, 8'hFF);
    rd(`SQG_OFS_DSCP_LAST, 8'h77);
    rd(`SQG_OFS_SNOOP_CTRL, 8'h4D);
    rd(`SQG_OFS_COLOR_MAP, 8'h3F);
    rd(`SQG_OFS_PTP_EVENT, 8'h8F);
    rd(`SQG_OFS_PTP_NONEVT, 8'h8F);
    rd(16'h0371, 8'h00);
    @(posedge sys_clk);
    clkEn <= 1'b0;
    wr(`SQG_OFS_DSCP_LAST, 8'h00);
    clkEn <= 1'b1;
    rd(`SQG_OFS_DSCP_LAST, 8'h77);
    $display("access and reserved bits done");

    wr(`SQG_OFS_DSCP_LAST, 8'h53);
    dscp(6'h3F, 1'b1, 3'h5);
    dscp(6'h3E, 1'b1, 3'h3);
    dscp(6'h3D, 1'b0, 3'h3);
    wr(`SQG_OFS_DSCP_LAST, 8'h26);
    dscp(6'h3F, 1'b1, 3'h2);
    dscp(6'h3E, 1'b1, 3'h6);
    $display("dscp mapping done");

    for (int e = 0; e < 2; e++) begin
      wr(`SQG_OFS_SNOOP_CTRL, e ? 8'h40 : 8'h00);
      @(posedge sys_clk);
      pktIsIgmp <= 1'b1;
      pulse();
      chk(igmpToHost, e[0]);
    end
    for (int c = 0; c < 3; c++) begin
      wr(`SQG_OFS_SNOOP_CTRL, ctrls[c]);
      for (int i = 0; i < 16; i++) begin
        @(posedge sys_clk);
        nextHdr    <= i[3] ? 8'h00 : hdrs[i[2:0]];
        hopNextHdr <= i[3] ? hdrs[i[2:0]] : 8'h3A;
        ipv6Valid  <= 1'b1;
        pulse();
        if (ctrls[c][3])
          hit = hdrs[i[2:0]] inside {8'h2B, 8'h2C, 8'h32, 8'h33, 8'h3C};
        else
          hit = hdrs[i[2:0]] inside {8'h01, 8'h3A};
        chk(mldToHost, hit & ctrls[c][2]);
      end
    end
    $display("snooping done");

    for (int m = 0; m < 16; m++) begin
      if (m[2:0] == 3'h0)
        wr(`SQG_OFS_SNOOP_CTRL, {7'h00, m[3]});
      @(posedge sys_clk);
      mirValid     <= 1'b1;
      portMirrorEn <= m[2];
      srcMatch     <= m[1];
      dstMatch     <= m[0];
      pulse();
      chk(mirrorFrame, m[2] & (m[3] ? (m[1] & m[0]) : (m[1] | m[0])));
    end
    $display("mirror filter done");

    wr(`SQG_OFS_COLOR_MAP, 8'hDB);
    @(posedge sys_clk);
    #1;
    chk({redDscp, yellowDscp, greenDscp}, 8'h1B);
    rd(`SQG_OFS_COLOR_MAP, 8'h1B);
    $display("colour mapping done");

    wr(`SQG_OFS_PTP_EVENT, 8'h85);
    wr(`SQG_OFS_PTP_NONEVT, 8'h0A);
    ptp(1'b1, 4'h2, 4'h5);
    ptp(1'b0, 4'h2, 4'h2);
    wr(`SQG_OFS_PTP_EVENT, 8'h05);
    wr(`SQG_OFS_PTP_NONEVT, 8'h8A);
    ptp(1'b1, 4'h9, 4'h9);
    ptp(1'b0, 4'h9, 4'hA);
    $display("ptp override done");
    complete_run();
  end
endmodule : sqg_global_ctrl_tb

// ==== verilog/sqg_global_ctrl.sv ====
/*
  Global QoS, snooping and mirror control group of the switch: five
  8-bit registers on a plain strobe port, and the classification
  decisions they steer (DSCP 0x3E/0x3F priority, IGMP/MLD snooping,
  sniff filter, WRED colour DSCP, PTP priority override).
  Assumes all classifier inputs come from logic on sys_clk.
*/
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "sqg_params.svh"

// Operation
// - DSCP 0x3F uses map bits 6:4
// - DSCP 0x3E uses map bits 2:0
// - Group snoop enable sends IGMP to host
// - Listener snoop enable sends MLD to host
// - Option set: extension headers mark MLD
// - Option clear: ICMP headers mark MLD
// - AND mode needs source and destination match
// - OR mode needs either port match
// - Mirroring also needs per-port ingress setting
// - Red colour DSCP bits 5:4, reset 11
// - Yellow colour DSCP bits 3:2, reset 10
// - Green colour DSCP bits 1:0, reset 01
// - Event override clear uses QoS priority
// - Event override set forces bits 3:0
// - Non-event override clear uses QoS priority
// - Non-event override set forces bits 3:0
module sqg_global_ctrl #(
  parameter int ADDR_W = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              clkEn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire sqg_pkg::sqg_byte_t regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output sqg_pkg::sqg_byte_t     regRdata,
  input  wire logic              dscpValid,
  input  wire sqg_pkg::sqg_dscp_t dscpIn,
  output logic                   dscpHit,
  output sqg_pkg::sqg_prio3_t    dscpPrio,
  input  wire logic              pktIsIgmp,
  output logic                   igmpToHost,
  input  wire logic              ipv6Valid,
  input  wire sqg_pkg::sqg_byte_t nextHdr,
  input  wire sqg_pkg::sqg_byte_t hopNextHdr,
  output logic                   mldToHost,
  input  wire logic              mirValid,
  input  wire logic              portMirrorEn,
  input  wire logic              srcMatch,
  input  wire logic              dstMatch,
  output logic                   mirrorFrame,
  output sqg_pkg::sqg_color_t    redDscp,
  output sqg_pkg::sqg_color_t    yellowDscp,
  output sqg_pkg::sqg_color_t    greenDscp,
  input  wire logic              ptpValid,
  input  wire logic              ptpIsEvent,
  input  wire sqg_pkg::sqg_prio4_t qosPrio,
  output logic                   ptpEvValid,
  output sqg_pkg::sqg_prio4_t    ptpEvPrio,
  output logic                   ptpNeValid,
  output sqg_pkg::sqg_prio4_t    ptpNePrio
);
  import sqg_pkg::*;

  if (ADDR_W < `SQG_MIN_ADDR_W || ADDR_W > 16) begin : g_bad_addr
    $error("sqg_global_ctrl: ADDR_W must lie in 10..16");
  end

  sqg_byte_t dscpLast_q;
  sqg_byte_t snoopCtrl_q;
  sqg_byte_t colorMap_q;
  sqg_byte_t ptpEvent_q;
  sqg_byte_t ptpNonEvt_q;
  sqg_byte_t regRdata_q;
  sqg_byte_t regRdata_d;
  sqg_reg_e  regSel;
  logic      listenMatch;

  function automatic sqg_reg_e decodeAddr(input logic [ADDR_W-1:0] a);
    decodeAddr = SQG_SEL_NONE;
    if (a == ADDR_W'(`SQG_OFS_DSCP_LAST)) begin
      decodeAddr = SQG_SEL_DSCP_LAST;
    end else if (a == ADDR_W'(`SQG_OFS_SNOOP_CTRL)) begin
      decodeAddr = SQG_SEL_SNOOP_CTRL;
    end else if (a == ADDR_W'(`SQG_OFS_COLOR_MAP)) begin
      decodeAddr = SQG_SEL_COLOR_MAP;
    end else if (a == ADDR_W'(`SQG_OFS_PTP_EVENT)) begin
      decodeAddr = SQG_SEL_PTP_EVENT;
    end else if (a == ADDR_W'(`SQG_OFS_PTP_NONEVT)) begin
      decodeAddr = SQG_SEL_PTP_NONEVT;
    end
  endfunction : decodeAddr

  // Next-header sets that qualify as listener discovery
  function automatic logic isListenerHdr(input sqg_byte_t h, input logic opt);
    if (opt) begin
      isListenerHdr = (h == `SQG_NH_ROUTING) || (h == `SQG_NH_FRAGMENT) ||
                      (h == `SQG_NH_ESP) || (h == `SQG_NH_AUTH) ||
                      (h == `SQG_NH_DEST_OPT);
    end else begin
      isListenerHdr = (h == `SQG_NH_ICMP4) || (h == `SQG_NH_ICMP6);
    end
  endfunction : isListenerHdr

  assign regSel = decodeAddr(regAddr);

  // Masks drop writes to reserved positions
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dscpLast_q <= `SQG_RST_DSCP_LAST;
    end else if (clkEn && regWr && regSel == SQG_SEL_DSCP_LAST) begin
      dscpLast_q <= regWdata & `SQG_MSK_DSCP_LAST;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      snoopCtrl_q <= `SQG_RST_SNOOP_CTRL;
    end else if (clkEn && regWr && regSel == SQG_SEL_SNOOP_CTRL) begin
      snoopCtrl_q <= regWdata & `SQG_MSK_SNOOP_CTRL;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      colorMap_q <= `SQG_RST_COLOR_MAP;
    end else if (clkEn && regWr && regSel == SQG_SEL_COLOR_MAP) begin
      colorMap_q <= regWdata & `SQG_MSK_COLOR_MAP;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ptpEvent_q <= `SQG_RST_PTP;
    end else if (clkEn && regWr && regSel == SQG_SEL_PTP_EVENT) begin
      ptpEvent_q <= regWdata & `SQG_MSK_PTP;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ptpNonEvt_q <= `SQG_RST_PTP;
    end else if (clkEn && regWr && regSel == SQG_SEL_PTP_NONEVT) begin
      ptpNonEvt_q <= regWdata & `SQG_MSK_PTP;
    end
  end

  always_comb begin
    regRdata_d = 8'h00;
    if (regRd) begin
      unique case (regSel)
        SQG_SEL_DSCP_LAST:  regRdata_d = dscpLast_q;
        SQG_SEL_SNOOP_CTRL: regRdata_d = snoopCtrl_q;
        SQG_SEL_COLOR_MAP:  regRdata_d = colorMap_q;
        SQG_SEL_PTP_EVENT:  regRdata_d = ptpEvent_q;
        SQG_SEL_PTP_NONEVT: regRdata_d = ptpNonEvt_q;
        SQG_SEL_NONE:       regRdata_d = 8'h00;
      endcase
    end
  end

  // Read data only in the cycle after a clkEn strobe, zero after that; held while clkEn is low
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      regRdata_q <= 8'h00;
    end else if (clkEn) begin
      regRdata_q <= regRdata_d;
    end
  end

  assign regRdata = regRdata_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dscpHit  <= 1'b0;
      dscpPrio <= 3'h0;
    end else if (clkEn) begin
      dscpHit <= dscpValid &&
                 (dscpIn == `SQG_DSCP_CODE_HI || dscpIn == `SQG_DSCP_CODE_LO);
      if (dscpValid && dscpIn == `SQG_DSCP_CODE_HI) begin
        dscpPrio <= dscpLast_q[`SQG_DSCP_HI_MSB:`SQG_DSCP_HI_LSB];
      end else if (dscpValid && dscpIn == `SQG_DSCP_CODE_LO) begin
        dscpPrio <= dscpLast_q[`SQG_DSCP_LO_MSB:`SQG_DSCP_LO_LSB];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      igmpToHost <= 1'b0;
    end else if (clkEn) begin
      igmpToHost <= pktIsIgmp && snoopCtrl_q[`SQG_BIT_GROUP_SNOOP];
    end
  end

  // Direct header, or hop-by-hop header followed by a qualifying one
  assign listenMatch =
    isListenerHdr(nextHdr, snoopCtrl_q[`SQG_BIT_LISTEN_OPT]) ||
    (nextHdr == `SQG_NH_HOP_BY_HOP &&
     isListenerHdr(hopNextHdr, snoopCtrl_q[`SQG_BIT_LISTEN_OPT]));

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mldToHost <= 1'b0;
    end else if (clkEn) begin
      mldToHost <= ipv6Valid && listenMatch &&
                   snoopCtrl_q[`SQG_BIT_LISTEN_EN];
    end
  end

  // Global filter alone never mirrors; the port setting must agree
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mirrorFrame <= 1'b0;
    end else if (clkEn) begin
      mirrorFrame <= mirValid && portMirrorEn &&
                     (snoopCtrl_q[`SQG_BIT_SNIFF_AND] ?
                      (srcMatch && dstMatch) :
                      (srcMatch || dstMatch));
    end
  end

  assign redDscp    = colorMap_q[`SQG_RED_MSB:`SQG_RED_LSB];
  assign yellowDscp = colorMap_q[`SQG_YELLOW_MSB:`SQG_YELLOW_LSB];
  assign greenDscp  = colorMap_q[`SQG_GREEN_MSB:`SQG_GREEN_LSB];

  sqg_prio_override #(
    .PRIO_W(4)
  ) u_event_prio (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .clkEn      (clkEn),
    .msgValid   (ptpValid && ptpIsEvent),
    .overrideEn (ptpEvent_q[`SQG_BIT_PTP_OVR]),
    .forcedPrio (ptpEvent_q[`SQG_PTP_PRIO_MSB:`SQG_PTP_PRIO_LSB]),
    .qosPrio    (qosPrio),
    .prioValid  (ptpEvValid),
    .prio       (ptpEvPrio)
  );

  sqg_prio_override #(
    .PRIO_W(4)
  ) u_nonevent_prio (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .clkEn      (clkEn),
    .msgValid   (ptpValid && !ptpIsEvent),
    .overrideEn (ptpNonEvt_q[`SQG_BIT_PTP_OVR]),
    .forcedPrio (ptpNonEvt_q[`SQG_PTP_PRIO_MSB:`SQG_PTP_PRIO_LSB]),
    .qosPrio    (qosPrio),
    .prioValid  (ptpNeValid),
    .prio       (ptpNePrio)
  );

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence s_colorWr;
    clkEn && regWr && regAddr == ADDR_W'(`SQG_OFS_COLOR_MAP);
  endsequence

  sequence s_colorRd;
    clkEn && regRd && regAddr == ADDR_W'(`SQG_OFS_COLOR_MAP);
  endsequence

  sequence s_ctrlWr;
    clkEn && regWr && regAddr == ADDR_W'(`SQG_OFS_SNOOP_CTRL);
  endsequence

  property p_dscpHi;
    clkEn && dscpValid && dscpIn == `SQG_DSCP_CODE_HI |=>
      dscpHit && dscpPrio == $past(dscpLast_q[6:4]);
  endproperty
  a_dscpHi: assert property (p_dscpHi) else $error("DSCP 3F priority wrong");

  property p_dscpLo;
    clkEn && dscpValid && dscpIn == `SQG_DSCP_CODE_LO |=>
      dscpHit && dscpPrio == $past(dscpLast_q[2:0]);
  endproperty
  a_dscpLo: assert property (p_dscpLo) else $error("DSCP 3E priority wrong");

  property p_groupSnoop;
    clkEn |=> igmpToHost == ($past(pktIsIgmp) && $past(snoopCtrl_q[6]));
  endproperty
  a_groupSnoop: assert property (p_groupSnoop) else $error("IGMP snoop wrong");

  property p_listenOff;
    clkEn && !snoopCtrl_q[2] |=> !mldToHost;
  endproperty
  a_listenOff: assert property (p_listenOff) else $error("MLD while disabled");

  property p_listenOpt;
    clkEn && ipv6Valid && snoopCtrl_q[2] && snoopCtrl_q[3] &&
      nextHdr == `SQG_NH_HOP_BY_HOP && hopNextHdr == `SQG_NH_DEST_OPT |=> mldToHost;
  endproperty
  a_listenOpt: assert property (p_listenOpt) else $error("MLD option miss");

  property p_listenStd;
    clkEn && ipv6Valid && snoopCtrl_q[2] && !snoopCtrl_q[3] &&
      nextHdr == `SQG_NH_ROUTING |=> !mldToHost;
  endproperty
  a_listenStd: assert property (p_listenStd) else $error("MLD std false hit");

  property p_mirrorAnd;
    clkEn && mirValid && portMirrorEn && snoopCtrl_q[0] && srcMatch != dstMatch
      |=> !mirrorFrame;
  endproperty
  a_mirrorAnd: assert property (p_mirrorAnd) else $error("AND sniff leaked");

  property p_mirrorOr;
    clkEn && mirValid && portMirrorEn && !snoopCtrl_q[0] && srcMatch
      |=> mirrorFrame;
  endproperty
  a_mirrorOr: assert property (p_mirrorOr) else $error("OR sniff missed");

  property p_mirrorGate;
    clkEn && !portMirrorEn |=> !mirrorFrame;
  endproperty
  a_mirrorGate: assert property (p_mirrorGate) else $error("Mirror w/o port");

  property p_colorWr;
    s_colorWr ##1 (!regWr || !clkEn) |->
      {redDscp, yellowDscp, greenDscp} == $past(regWdata[5:0]);
  endproperty
  a_colorWr: assert property (p_colorWr) else $error("Colour write lost");

  property p_reservedRd;
    s_colorRd |=> regRdata[7:6] == 2'h0 && regRdata[5:0] == $past(colorMap_q[5:0]);
  endproperty
  a_reservedRd: assert property (p_reservedRd) else $error("Reserved bits read");

  property p_ctrlMask;
    s_ctrlWr |=> snoopCtrl_q[7] == 1'b0 && snoopCtrl_q[5:4] == 2'h0;
  endproperty
  a_ctrlMask: assert property (p_ctrlMask) else $error("Reserved ctrl stored");

  property p_ptpEvent;
    clkEn && ptpValid && ptpIsEvent |=> ptpEvValid && ptpEvPrio ==
      ($past(ptpEvent_q[7]) ? $past(ptpEvent_q[3:0]) : $past(qosPrio));
  endproperty
  a_ptpEvent: assert property (p_ptpEvent) else $error("PTP event prio");

  property p_ptpNonEvt;
    clkEn && ptpValid && !ptpIsEvent |=> ptpNeValid && !ptpEvValid && ptpNePrio ==
      ($past(ptpNonEvt_q[7]) ? $past(ptpNonEvt_q[3:0]) : $past(qosPrio));
  endproperty
  a_ptpNonEvt: assert property (p_ptpNonEvt) else $error("PTP non-event prio");
endmodule : sqg_global_ctrl

// ==== verilog/sqg_params.svh ====
/*
  Offsets, field positions, masks, reset values and code points of the
  switch QoS / snooping global control group.
  Assumes byte addressing at the printed offsets and 8-bit registers.
*/
`ifndef SQG_PARAMS_SVH
`define SQG_PARAMS_SVH

`define SQG_OFS_DSCP_LAST   16'h035F
`define SQG_OFS_SNOOP_CTRL  16'h0370
`define SQG_OFS_COLOR_MAP   16'h0378
`define SQG_OFS_PTP_EVENT   16'h037C
`define SQG_OFS_PTP_NONEVT  16'h037D
`define SQG_MIN_ADDR_W      10

`define SQG_RST_DSCP_LAST   8'h00
`define SQG_RST_SNOOP_CTRL  8'h00
`define SQG_RST_COLOR_MAP   8'h39
`define SQG_RST_PTP         8'h0F

`define SQG_MSK_DSCP_LAST   8'h77
`define SQG_MSK_SNOOP_CTRL  8'h4D
`define SQG_MSK_COLOR_MAP   8'h3F
`define SQG_MSK_PTP         8'h8F

`define SQG_DSCP_CODE_HI    6'h3F
`define SQG_DSCP_CODE_LO    6'h3E
`define SQG_DSCP_HI_MSB     6
`define SQG_DSCP_HI_LSB     4
`define SQG_DSCP_LO_MSB     2
`define SQG_DSCP_LO_LSB     0

`define SQG_BIT_GROUP_SNOOP 6
`define SQG_BIT_LISTEN_OPT  3
`define SQG_BIT_LISTEN_EN   2
`define SQG_BIT_SNIFF_AND   0

`define SQG_RED_MSB         5
`define SQG_RED_LSB         4
`define SQG_YELLOW_MSB      3
`define SQG_YELLOW_LSB      2
`define SQG_GREEN_MSB       1
`define SQG_GREEN_LSB       0

`define SQG_BIT_PTP_OVR     7
`define SQG_PTP_PRIO_MSB    3
`define SQG_PTP_PRIO_LSB    0

`define SQG_NH_HOP_BY_HOP   8'h00
`define SQG_NH_ICMP4        8'h01
`define SQG_NH_ICMP6        8'h3A
`define SQG_NH_ROUTING      8'h2B
`define SQG_NH_FRAGMENT     8'h2C
`define SQG_NH_ESP          8'h32
`define SQG_NH_AUTH         8'h33
`define SQG_NH_DEST_OPT     8'h3C

`endif

// ==== verilog/sqg_pkg.sv ====
/*
  Types shared by the global control group and its testbench.
  Assumes sqg_params.svh carries all numeric constants.
*/
package sqg_pkg;
  typedef logic [7:0] sqg_byte_t;
  typedef logic [5:0] sqg_dscp_t;
  typedef logic [2:0] sqg_prio3_t;
  typedef logic [3:0] sqg_prio4_t;
  typedef logic [1:0] sqg_color_t;
  typedef enum {
    SQG_SEL_NONE,
    SQG_SEL_DSCP_LAST,
    SQG_SEL_SNOOP_CTRL,
    SQG_SEL_COLOR_MAP,
    SQG_SEL_PTP_EVENT,
    SQG_SEL_PTP_NONEVT
  } sqg_reg_e;
endpackage : sqg_pkg

// ==== verilog/sqg_prio_override.sv ====
/*
  Registered priority selector for one PTP message class: forced priority
  while override is set, else the classified QoS priority.
  Assumes all inputs come from logic on sys_clk.
*/
`timescale 1ns/100ps
module sqg_prio_override #(
  parameter int PRIO_W = 4
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              clkEn,
  input  wire logic              msgValid,
  input  wire logic              overrideEn,
  input  wire logic [PRIO_W-1:0] forcedPrio,
  input  wire logic [PRIO_W-1:0] qosPrio,
  output logic                   prioValid,
  output logic      [PRIO_W-1:0] prio
);
  if (PRIO_W < 1) begin : g_bad_width
    $error("sqg_prio_override: PRIO_W must be at least 1");
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prioValid <= 1'b0;
    end else if (clkEn) begin
      prioValid <= msgValid;
    end
  end

  // Priority held between messages so the queue side may sample late
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prio <= '0;
    end else if (clkEn && msgValid) begin
      prio <= overrideEn ? forcedPrio : qosPrio;
    end
  end
endmodule : sqg_prio_override
